/* rtl/dsw_pkg.sv */
// Purpose: shared constants and types of the stream-to-memory write channel
// Assumes: one clock, synchronous active-high reset
// Notes:   register offsets are byte addresses on the plain register port
package dsw_pkg;

   // data path widths, fixed at build
   localparam int MM_W     = 32;  // memory write bus, 32..1024 [R5]
   localparam int STREAM_W = 32;  // stream width, 8..1024, <= MM_W [R6]
   localparam int STRB_W   = MM_W / 8;
   localparam int LEN_W    = 23;  // valid bits of a length value [R15]
   localparam bit REALIGN_OK = (STREAM_W <= 64);  // realigner exists [R9]

   // register byte offsets
   localparam logic [7:0] OFF_CTRL     = 8'h00;
   localparam logic [7:0] OFF_ADDR     = 8'h04;
   localparam logic [7:0] OFF_LENGTH   = 8'h08;
   localparam logic [7:0] OFF_STATUS   = 8'h0c;
   localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
   localparam logic [7:0] OFF_IRQ_CLR  = 8'h14;
   localparam logic [7:0] OFF_IRQ_EN   = 8'h18;
   localparam logic [7:0] OFF_BURST    = 8'h1c;
   localparam logic [7:0] OFF_CLK_FREQ = 8'h20;

   // control bits
   localparam int CTRL_W         = 5;
   localparam int CTRL_RUN       = 0;
   localparam int CTRL_STS_EN    = 1;
   localparam int CTRL_USE_RXLEN = 2;
   localparam int CTRL_REALIGN   = 3;
   localparam int CTRL_ASYNC     = 4;
   localparam int LEN_DONE_BIT   = 31;  // descriptor already completed

   // status bits
   localparam int STS_IDLE  = 0;
   localparam int STS_BUSY  = 1;
   localparam int STS_UNAL  = 2;
   localparam int STS_ERR_LO = 4;

   // event bits of the interrupt status
   localparam int EV_N       = 5;
   localparam int EV_DONE    = 0;
   localparam int EV_INT_ERR = 1;
   localparam int EV_SG_ERR  = 2;
   localparam int EV_SLV_ERR = 3;
   localparam int EV_DEC_ERR = 4;

   // write responses
   localparam logic [1:0] RESP_SLV = 2'h2;
   localparam logic [1:0] RESP_DEC = 2'h3;

   // status packet: word 0 flags, then user fields zero to four
   localparam logic [2:0] STS_FIELD_FOUR_IDX = 3'h5;

   // burst size code: beats = 16 << code, code 0..4
   localparam logic [8:0] BURST_MIN   = 9'h010;
   localparam logic [2:0] BURST_MAXC  = 3'h4;
   localparam logic [2:0] BURST_RST   = 3'h0;
   localparam logic [31:0] CLK_FREQ_RST = 32'h017d7840;
   localparam int BUF_DEPTH = 256;  // one largest burst

   typedef enum logic [6:0] {
      ST_IDLE     = 7'h01,
      ST_WAIT_LEN = 7'h02,
      ST_PLAN     = 7'h04,
      ST_FILL     = 7'h08,
      ST_ADDR     = 7'h10,
      ST_DATA     = 7'h20,
      ST_RESP     = 7'h40
   } dsw_state_t;

   typedef struct packed {
      logic [31:0] addr;
      logic [7:0]  len;
   } dsw_aw_t;

   typedef struct packed {
      logic [MM_W-1:0]   data;
      logic [STRB_W-1:0] strb;
      logic              last;
   } dsw_w_t;

endpackage

/* rtl/dsw_realign.sv */
// Purpose: byte realigner, shifts stream words onto memory lanes
// Assumes: one step per memory beat, offset stable for a transfer
// Notes:   carry from the previous word fills the low lanes
`timescale 1ns/1ps
module dsw_realign (
   input  wire logic                         clk,
   input  wire logic                         sys_rst,
   input  wire logic                         step,
   input  wire logic [1:0]                   offset,
   input  wire logic [dsw_pkg::STREAM_W-1:0] in_data,
   output logic      [dsw_pkg::STREAM_W-1:0] out_data
);
   localparam int NB = dsw_pkg::STREAM_W / 8;
   localparam int IW = $clog2(2 * NB);

   logic [dsw_pkg::STREAM_W-1:0]   carry_q;
   logic [dsw_pkg::STREAM_W-1:0]   carry_d;
   logic [2*dsw_pkg::STREAM_W-1:0] joined;

   assign joined = {in_data, carry_q};

   // lane l takes byte NB+l-offset of carry and new word [R7]
   for (genvar l = 0; l < NB; l++) begin : g_lane
      logic [IW-1:0] idx;
      assign idx = IW'(NB + l) - IW'(offset);
      assign out_data[8*l +: 8] = joined[8*idx +: 8];
   end

   // keep the word just consumed
   always_comb begin
      carry_d = step ? in_data : carry_q;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         carry_q <= '0;
      end else begin
         carry_q <= carry_d;
      end
   end
endmodule

/* rtl/dsw_stream_to_memory_channel.sv */
// Purpose: stream-to-memory write channel with burst partitioning
// Assumes: 25 MHz clk, register port with read data one cycle later
// Notes:   a write to LENGTH starts a transfer when idle and the run bit is set
// Operation
// (R1) receive length from status field four
// (R2) receive-length mode skips store-and-forward
// (R3) source delivers every counted byte
// (R4) clock setting used only when asynchronous
// (R5) memory write width 32 to 1024
// (R6) stream width 8 to 1024, not wider
// (R7) realigner writes from any byte offset
// (R8) alignment judged against stream width
// (R9) realigner only up to 64 bits
// (R10) bursts capped at chosen beat count
// (R11) zero length sets internal error
// (R12) completed descriptor sets gather error
// (R13) error responses set slave/decode bits
// (R14) software follows programming order first
// (R15) length width limits field four bits
// (R16) receive-length needs status stream present
//
// Our own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module dsw_stream_wr (
   input  wire logic                         clk,
   input  wire logic                         sys_rst,
   input  wire logic [7:0]                   reg_addr,
   input  wire logic [31:0]                  reg_wdata,
   input  wire logic                         reg_wr,
   input  wire logic                         reg_rd,
   output logic      [31:0]                  reg_rdata,
   input  wire logic [dsw_pkg::STREAM_W-1:0] s_tdata,
   input  wire logic                         s_tvalid,
   output logic                              s_tready,
   input  wire logic [31:0]                  sts_tdata,
   input  wire logic                         sts_tvalid,
   input  wire logic                         sts_tlast,
   output logic                              sts_tready,
   output dsw_pkg::dsw_aw_t                  m_aw,
   output logic                              m_awvalid,
   input  wire logic                         m_awready,
   output dsw_pkg::dsw_w_t                   m_w,
   output logic                              m_wvalid,
   input  wire logic                         m_wready,
   input  wire logic [1:0]                   m_bresp,
   input  wire logic                         m_bvalid,
   output logic                              m_bready,
   output logic                              irq
);
   localparam int LW = dsw_pkg::LEN_W;
   localparam int PW = LW + 2;
   localparam int PP = PW + 2;
   localparam int NL = dsw_pkg::STRB_W;

   dsw_pkg::dsw_state_t     st_q, st_d;
   dsw_pkg::dsw_aw_t        aw_q, aw_d;
   dsw_pkg::dsw_w_t         w_q, w_d, beat;
   dsw_pkg::dsw_w_t         buf_q [dsw_pkg::BUF_DEPTH];
   logic [dsw_pkg::CTRL_W-1:0] ctrl_q, ctrl_d;
   logic [31:0]             base_q, base_d, freq_q, freq_d;
   logic [31:0]             rdata_q, rdata_d, cdc_cfg;
   logic [2:0]              benc_q, benc_d, sw_q, sw_d;
   logic [dsw_pkg::EV_N-1:0] ist_q, ist_d, ien_q, ien_d, ev, clr;
   logic [LW-1:0]           tot_q, tot_d, rxl_q, rxl_d;
   logic [PW-1:0]           bidx_q, bidx_d, beats_tot, words_tot, rem;
   logic [8:0]              blen_q, blen_d, bcnt_q, bcnt_d;
   logic [8:0]              max_beats, bsz;
   logic [1:0]              off_q, off_d;
   logic [NL-1:0]           strb;
   logic [dsw_pkg::MM_W-1:0] ra_data;
   logic irq_q, irq_d, unal_q, unal_d, rxm_q, rxm_d;
   logic awv_q, awv_d, wv_q, wv_d, brdy_q, brdy_d;
   logic trdy_q, trdy_d, srdy_q, srdy_d, rxv_q, rxv_d;
   logic len_wr, rx_mode, realign, need_word, acc, prod_ok;
   logic produce, buf_we, rxv_clr, start, need_d;

   assign reg_rdata  = rdata_q;
   assign s_tready   = trdy_q;
   assign sts_tready = srdy_q;
   assign m_aw       = aw_q;
   assign m_awvalid  = awv_q;
   assign m_w        = w_q;
   assign m_wvalid   = wv_q;
   assign m_bready   = brdy_q;
   assign irq        = irq_q;

   // mode decode and transfer sizing
   assign len_wr  = reg_wr && (reg_addr == dsw_pkg::OFF_LENGTH);
   assign rx_mode = ctrl_q[dsw_pkg::CTRL_STS_EN]
                    & ctrl_q[dsw_pkg::CTRL_USE_RXLEN];  // [R16]
   assign realign = dsw_pkg::REALIGN_OK
                    & ctrl_q[dsw_pkg::CTRL_REALIGN];  // [R9]
   assign cdc_cfg = ctrl_q[dsw_pkg::CTRL_ASYNC] ? freq_q : 32'h0;  // [R4]
   assign max_beats = dsw_pkg::BURST_MIN << ((benc_q > dsw_pkg::BURST_MAXC)
                      ? dsw_pkg::BURST_MAXC : benc_q);
   assign beats_tot = (PW'(off_q) + PW'(tot_q) + PW'(3)) >> 2;
   assign words_tot = (PW'(tot_q) + PW'(3)) >> 2;
   assign rem       = beats_tot - bidx_q;
   assign bsz       = (rem > PW'(max_beats)) ? max_beats : rem[8:0];  // [R10]
   assign need_word = bidx_q < words_tot;
   assign acc       = s_tvalid & trdy_q;
   assign prod_ok   = need_word ? acc : 1'b1;

   // stream words onto memory lanes, widths fixed [R5] [R6]
   dsw_realign dsw_realign_inst (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .step     (produce),
      .offset   (off_q),
      .in_data  (need_word ? s_tdata : '0),
      .out_data (ra_data)
   );

   // lane strobes: only bytes inside [offset, offset+length) [R7]
   for (genvar l = 0; l < NL; l++) begin : g_strb
      logic [PP-1:0] pos;
      assign pos = PP'({bidx_q, 2'b00}) + PP'(l);
      assign strb[l] = (pos >= PP'(off_q))
                       && (pos < PP'(off_q) + PP'(tot_q));
   end
   assign beat = '{data: ra_data, strb: strb,
                   last: (bcnt_q == blen_q - 9'h1)};

   // transfer sequencer
   always_comb begin
      st_d = st_q;
      tot_d = tot_q;
      off_d = off_q;
      bidx_d = bidx_q;
      blen_d = blen_q;
      bcnt_d = bcnt_q;
      aw_d = aw_q;
      w_d = w_q;
      wv_d = wv_q;
      rxm_d = rxm_q;
      unal_d = unal_q;
      ev = '0;
      produce = 1'b0;
      buf_we = 1'b0;
      rxv_clr = 1'b0;
      start = 1'b0;
      case (st_q)
         dsw_pkg::ST_IDLE: begin
            if (len_wr && ctrl_q[dsw_pkg::CTRL_RUN]) begin
               rxm_d = rx_mode;
               if (reg_wdata[dsw_pkg::LEN_DONE_BIT]) begin
                  ev[dsw_pkg::EV_SG_ERR] = 1'b1;  // [R12]
               end else if (rx_mode) begin
                  st_d = dsw_pkg::ST_WAIT_LEN;  // [R1]
               end else if (reg_wdata[LW-1:0] == '0) begin
                  ev[dsw_pkg::EV_INT_ERR] = 1'b1;  // [R11]
               end else begin
                  tot_d = reg_wdata[LW-1:0];
                  start = 1'b1;
               end
            end
         end
         dsw_pkg::ST_WAIT_LEN: begin
            if (rxv_q) begin
               rxv_clr = 1'b1;
               if (rxl_q == '0) begin
                  ev[dsw_pkg::EV_INT_ERR] = 1'b1;  // [R11]
                  st_d = dsw_pkg::ST_IDLE;
               end else begin
                  tot_d = rxl_q;  // exact count commanded [R1]
                  start = 1'b1;
               end
            end
         end
         dsw_pkg::ST_PLAN: begin
            blen_d = bsz;  // [R10]
            bcnt_d = '0;
            aw_d.addr = {base_q[31:2], 2'b00} + 32'({bidx_q, 2'b00});
            aw_d.len = 8'(bsz - 9'h1);
            st_d = rxm_q ? dsw_pkg::ST_ADDR : dsw_pkg::ST_FILL;  // [R2]
         end
         dsw_pkg::ST_FILL: begin
            if (prod_ok) begin
               produce = 1'b1;
               buf_we = 1'b1;
               bidx_d = bidx_q + PW'(1);
               bcnt_d = bcnt_q + 9'h1;
               if (beat.last) begin
                  bcnt_d = '0;
                  st_d = dsw_pkg::ST_ADDR;
               end
            end
         end
         dsw_pkg::ST_ADDR: begin
            if (awv_q && m_awready) begin
               st_d = dsw_pkg::ST_DATA;
            end
         end
         dsw_pkg::ST_DATA: begin
            if (wv_q && m_wready) begin
               wv_d = 1'b0;
               if (w_q.last) begin
                  st_d = dsw_pkg::ST_RESP;
               end
            end
            if (rxm_q) begin
               // straight from the stream, no holding buffer [R2]
               if (!wv_q && bcnt_q < blen_q && prod_ok) begin
                  produce = 1'b1;
                  w_d = beat;
                  wv_d = 1'b1;
                  bidx_d = bidx_q + PW'(1);
                  bcnt_d = bcnt_q + 9'h1;
               end
            end else if ((!wv_q || m_wready) && bcnt_q < blen_q) begin
               w_d = buf_q[bcnt_q[7:0]];
               wv_d = 1'b1;
               bcnt_d = bcnt_q + 9'h1;
            end
         end
         dsw_pkg::ST_RESP: begin
            if (m_bvalid && brdy_q) begin
               ev[dsw_pkg::EV_SLV_ERR] = (m_bresp == dsw_pkg::RESP_SLV);
               ev[dsw_pkg::EV_DEC_ERR] = (m_bresp == dsw_pkg::RESP_DEC);
               if (m_bresp[1]) begin
                  st_d = dsw_pkg::ST_IDLE;  // halt on error [R13]
               end else if (bidx_q == beats_tot) begin
                  ev[dsw_pkg::EV_DONE] = 1'b1;
                  st_d = dsw_pkg::ST_IDLE;
               end else begin
                  st_d = dsw_pkg::ST_PLAN;
               end
            end
         end
         default: begin
            st_d = dsw_pkg::ST_IDLE;
         end
      endcase
      if (start) begin
         // offset only honoured with the realigner [R8] [R9]
         off_d = realign ? base_q[1:0] : 2'b00;
         unal_d = (base_q[1:0] != 2'b00) && !realign;
         bidx_d = '0;
         st_d = dsw_pkg::ST_PLAN;
      end
   end

   // handshake outputs follow the next state
   assign need_d = bidx_d < words_tot;
   always_comb begin
      awv_d = (st_d == dsw_pkg::ST_ADDR);
      brdy_d = (st_d == dsw_pkg::ST_RESP);
      trdy_d = need_d && ((st_d == dsw_pkg::ST_FILL)
               || (st_d == dsw_pkg::ST_DATA && rxm_q && !wv_d
                   && bcnt_d < blen_d));
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st_q <= dsw_pkg::ST_IDLE;
         tot_q <= '0;
         off_q <= '0;
         bidx_q <= '0;
         blen_q <= '0;
         bcnt_q <= '0;
         aw_q <= '0;
         w_q <= '0;
         wv_q <= 1'b0;
         rxm_q <= 1'b0;
         unal_q <= 1'b0;
         awv_q <= 1'b0;
         brdy_q <= 1'b0;
         trdy_q <= 1'b0;
      end else begin
         st_q <= st_d;
         tot_q <= tot_d;
         off_q <= off_d;
         bidx_q <= bidx_d;
         blen_q <= blen_d;
         bcnt_q <= bcnt_d;
         aw_q <= aw_d;
         w_q <= w_d;
         wv_q <= wv_d;
         rxm_q <= rxm_d;
         unal_q <= unal_d;
         awv_q <= awv_d;
         brdy_q <= brdy_d;
         trdy_q <= trdy_d;
      end
   end

   // store-and-forward burst buffer
   always_ff @(posedge clk) begin
      if (buf_we) begin
         buf_q[bcnt_q[7:0]] <= beat;
      end
   end

   // status stream: catch user field four
   always_comb begin
      sw_d = sw_q;
      rxl_d = rxl_q;
      rxv_d = rxv_q & ~rxv_clr;
      srdy_d = ctrl_q[dsw_pkg::CTRL_STS_EN];
      if (sts_tvalid && srdy_q) begin
         if (sw_q == dsw_pkg::STS_FIELD_FOUR_IDX) begin
            rxl_d = sts_tdata[LW-1:0];  // [R1] [R15]
            rxv_d = 1'b1;
         end
         sw_d = sts_tlast ? 3'h0 : ((sw_q == 3'h7) ? sw_q : sw_q + 3'h1);
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sw_q <= '0;
         rxl_q <= '0;
         rxv_q <= 1'b0;
         srdy_q <= 1'b0;
      end else begin
         sw_q <= sw_d;
         rxl_q <= rxl_d;
         rxv_q <= rxv_d;
         srdy_q <= srdy_d;
      end
   end

   // register port and interrupt
   always_comb begin
      ctrl_d = ctrl_q;
      base_d = base_q;
      freq_d = freq_q;
      benc_d = benc_q;
      ien_d = ien_q;
      rdata_d = 32'h0;
      clr = '0;
      if (reg_wr) begin
         case (reg_addr)
            dsw_pkg::OFF_CTRL:     ctrl_d = reg_wdata[dsw_pkg::CTRL_W-1:0];
            dsw_pkg::OFF_ADDR:     base_d = reg_wdata;
            dsw_pkg::OFF_BURST:    benc_d = reg_wdata[2:0];
            dsw_pkg::OFF_CLK_FREQ: freq_d = reg_wdata;
            dsw_pkg::OFF_IRQ_EN:   ien_d = reg_wdata[dsw_pkg::EV_N-1:0];
            dsw_pkg::OFF_IRQ_CLR:  clr = reg_wdata[dsw_pkg::EV_N-1:0];
            default: ;
         endcase
      end
      ist_d = (ist_q & ~clr) | ev;  // set wins over clear
      irq_d = |(ist_d & ien_d);
      if (reg_rd) begin
         case (reg_addr)
            dsw_pkg::OFF_CTRL:     rdata_d = 32'(ctrl_q);
            dsw_pkg::OFF_ADDR:     rdata_d = base_q;
            dsw_pkg::OFF_LENGTH:   rdata_d = 32'(tot_q);
            dsw_pkg::OFF_STATUS: begin
               rdata_d[dsw_pkg::STS_IDLE] = (st_q == dsw_pkg::ST_IDLE);
               rdata_d[dsw_pkg::STS_BUSY] = (st_q != dsw_pkg::ST_IDLE);
               rdata_d[dsw_pkg::STS_UNAL] = unal_q;
               rdata_d[dsw_pkg::STS_ERR_LO +: 4] = ist_q[4:1];
            end
            dsw_pkg::OFF_IRQ_STAT: rdata_d = 32'(ist_q);
            dsw_pkg::OFF_IRQ_EN:   rdata_d = 32'(ien_q);
            dsw_pkg::OFF_BURST:    rdata_d = 32'(benc_q);
            dsw_pkg::OFF_CLK_FREQ: rdata_d = cdc_cfg;  // [R4]
            default:               rdata_d = 32'h0;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ctrl_q <= '0;
         base_q <= '0;
         freq_q <= dsw_pkg::CLK_FREQ_RST;
         benc_q <= dsw_pkg::BURST_RST;
         ien_q <= '0;
         ist_q <= '0;
         irq_q <= 1'b0;
         rdata_q <= '0;
      end else begin
         ctrl_q <= ctrl_d;
         base_q <= base_d;
         freq_q <= freq_d;
         benc_q <= benc_d;
         ien_q <= ien_d;
         ist_q <= ist_d;
         irq_q <= irq_d;
         rdata_q <= rdata_d;
      end
   end

   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   sequence seq_go;
      st_q == dsw_pkg::ST_IDLE && len_wr && ctrl_q[dsw_pkg::CTRL_RUN];
   endsequence
   sequence seq_rx_ready;
      st_q == dsw_pkg::ST_WAIT_LEN && rxv_q && rxl_q != '0;
   endsequence

   chk_zero_len_err: assert property ( // [R11]
      seq_go ##0 (!rx_mode && !reg_wdata[31] && reg_wdata[LW-1:0] == '0)
      |=> ist_q[dsw_pkg::EV_INT_ERR] && st_q == dsw_pkg::ST_IDLE)
      else $error("zero length did not flag internal error");
   chk_done_desc_err: assert property ( // [R12]
      seq_go ##0 reg_wdata[31]
      |=> ist_q[dsw_pkg::EV_SG_ERR] && st_q == dsw_pkg::ST_IDLE)
      else $error("completed descriptor not flagged");
   chk_slave_err: assert property ( // [R13]
      m_bvalid && m_bready && m_bresp == dsw_pkg::RESP_SLV
      |=> ist_q[dsw_pkg::EV_SLV_ERR] && st_q == dsw_pkg::ST_IDLE)
      else $error("slave error response lost");
   chk_decode_err: assert property ( // [R13]
      m_bvalid && m_bready && m_bresp == dsw_pkg::RESP_DEC
      |=> ist_q[dsw_pkg::EV_DEC_ERR])
      else $error("decode error response lost");
   chk_burst_cap: assert property ( // [R10]
      $rose(m_awvalid) |-> {1'b0, m_aw.len} < max_beats)
      else $error("burst longer than the chosen maximum");
   chk_rxlen_taken: assert property ( // [R1] [R15]
      seq_rx_ready |=> tot_q == $past(rxl_q) && st_q == dsw_pkg::ST_PLAN)
      else $error("receive length not used as transfer count");
   chk_no_store_wait: assert property ( // [R2]
      st_q == dsw_pkg::ST_PLAN && rxm_q |=> m_awvalid ##0 !m_wvalid)
      else $error("receive-length mode waited for data");
   chk_first_lane: assert property ( // [R7]
      produce && bidx_q == '0 && need_word
      |-> ra_data[8*off_q +: 8] == s_tdata[7:0] && strb[off_q])
      else $error("first stream byte not at buffer offset");
   chk_align_drop: assert property ( // [R8] [R9]
      start && !realign |=> off_q == 2'b00)
      else $error("offset used without realigner");
   chk_clk_ignored: assert property ( // [R4]
      reg_rd && reg_addr == dsw_pkg::OFF_CLK_FREQ
      && !ctrl_q[dsw_pkg::CTRL_ASYNC] |=> reg_rdata == 32'h0)
      else $error("clock setting visible while synchronous");
endmodule

/* testbench/dsw_mem_model.sv */
// Purpose: memory side model, takes bursts and answers each with a response
// Assumes: one clock, synchronous active-high reset
// Notes:   slow adds random stalls; resp picks the burst response
`timescale 1ns/1ps
module dsw_mem_model (
   input  wire logic       clk,
   input  wire logic       sys_rst,
   input  wire logic       slow,
   input  wire logic [1:0] resp,
   input  wire logic       m_wvalid,
   input  wire logic       w_last,
   input  wire logic       m_bready,
   output logic            m_awready,
   output logic            m_wready,
   output logic [1:0]      m_bresp,
   output logic            m_bvalid
);
   logic pend_q;
   logic nv;
   // readies and one response per burst
   always @(posedge clk) begin
      if (sys_rst) begin
         m_awready <= 1'b0;
         m_wready <= 1'b0;
         m_bvalid <= 1'b0;
         m_bresp <= 2'h0;
         pend_q <= 1'b0;
      end else begin
         nv = (m_bvalid && !m_bready) || (pend_q && !m_bvalid);
         m_awready <= !slow || $urandom_range(1);
         m_wready <= !slow || $urandom_range(1);
         if (m_wvalid && m_wready && w_last)
            pend_q <= 1'b1;
         else if (pend_q && !m_bvalid)
            pend_q <= 1'b0;
         m_bvalid <= nv;
         // response line toggles while no answer stands
         m_bresp <= nv ? resp : ~m_bresp;
      end
   end
endmodule

/* testbench/dsw_stream_wr_tb_top.sv */
// Purpose: self-checking bench of the stream-to-memory write channel
// Assumes: 25 MHz clk, stream source and memory model beside the design
// Notes:   expected results queued by drivers, compared by one monitor
`timescale 1ns/1ps
module dsw_stream_wr_tb_top;
   logic             clk = 1'b0;
   logic             sys_rst = 1'b1;
   logic [7:0]       reg_addr = 8'h00;
   logic [31:0]      reg_wdata = 32'h0, s_tdata = 32'h0, sts_tdata = 32'h0;
   logic             reg_wr = 1'b0, reg_rd = 1'b0, s_tvalid = 1'b0;
   logic             sts_tvalid = 1'b0, sts_tlast = 1'b0, slow = 1'b0;
   logic             rd_p = 1'b0;
   logic [1:0]       resp = 2'h0, m_bresp;
   logic [31:0]      reg_rdata;
   logic             s_tready, sts_tready, m_awvalid, m_awready, m_wvalid;
   logic             m_wready, m_bvalid, m_bready, irq;
   dsw_pkg::dsw_aw_t m_aw;
   dsw_pkg::dsw_w_t  m_w;
   logic [39:0]      exp_rd[$], exp_aw[$], exp_w[$];
   logic [31:0]      src[$], prev = 32'h0;
   int               num_errors = 0, total_checks = 0, cyc = 0;

   always #20 clk = ~clk;

   dsw_stream_wr dsw_stream_wr_inst (.clk(clk), .sys_rst(sys_rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .s_tdata(s_tdata), .s_tvalid(s_tvalid),
      .s_tready(s_tready), .sts_tdata(sts_tdata), .sts_tvalid(sts_tvalid),
      .sts_tlast(sts_tlast), .sts_tready(sts_tready), .m_aw(m_aw),
      .m_awvalid(m_awvalid), .m_awready(m_awready), .m_w(m_w),
      .m_wvalid(m_wvalid), .m_wready(m_wready), .m_bresp(m_bresp),
      .m_bvalid(m_bvalid), .m_bready(m_bready), .irq(irq));
   dsw_mem_model dsw_mem_model_inst (.clk(clk), .sys_rst(sys_rst),
      .slow(slow), .resp(resp), .m_wvalid(m_wvalid), .w_last(m_w.last),
      .m_bready(m_bready), .m_awready(m_awready), .m_wready(m_wready),
      .m_bresp(m_bresp), .m_bvalid(m_bvalid));

   task automatic cmp(string what, logic [39:0] e, logic [39:0] g);
      total_checks++;
      if (g !== e) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic final_report;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // monitor, stream source and cycle ceiling
   always @(posedge clk) begin
      if (rd_p)
         cmp("reg_rdata", exp_rd.pop_front(), {8'h00, reg_rdata});
      rd_p <= reg_rd;
      if (m_awvalid && m_awready)
         cmp("m_aw", exp_aw.pop_front(), m_aw);
      if (m_wvalid && m_wready)
         cmp("m_w", exp_w.pop_front(), {3'h0, m_w});
      if (s_tvalid && s_tready)
         void'(src.pop_front());
      s_tvalid <= src.size() > 0; // every counted byte delivered
      s_tdata <= src.size() > 0 ? src[0] : ~s_tdata;
      cyc++;
      if (cyc == 30000) begin
         num_errors++;
         final_report();
      end
   end

   task automatic wr(logic [7:0] a, logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(logic [7:0] a, logic [31:0] e);
      exp_rd.push_back({8'h00, e});
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(posedge clk);
   endtask

   task automatic sts_send(logic [31:0] w5);
      @(posedge clk);
      for (int i = 0; i < 6; i++) begin
         sts_tdata <= (i == 5) ? w5 : $urandom;
         sts_tvalid <= 1'b1;
         sts_tlast <= (i == 5);
         do @(posedge clk); while (sts_tready !== 1'b1);
      end
      sts_tvalid <= 1'b0;
      sts_tdata <= ~sts_tdata;
   endtask

   // queue bursts and beats, then program address before length
   // an offset shifts each word up, low lanes keep the previous word
   task automatic xfer(logic [31:0] a, int n, int bmax, bit rx);
      int o, nb, j, b;
      logic [31:0] w;
      logic [63:0] jw;
      logic [3:0] s;
      o = int'(a[1:0]);
      nb = (o + 4 * n + 3) / 4;
      j = 0;
      while (j < nb) begin
         b = nb - j > bmax ? bmax : nb - j;
         exp_aw.push_back({{a[31:2], 2'b00} + 32'(4 * j), 8'(b - 1)});
         for (int k = 0; k < b; k++) begin
            w = j < n ? $urandom : 32'h0;
            if (j < n)
               src.push_back(w);
            jw = {w, prev} >> (32 - 8 * o);
            s = j == 0 ? 4'hf << o : (j == n ? ~(4'hf << o) : 4'hf);
            exp_w.push_back({3'h0, jw[31:0], s, k == b - 1});
            prev = w;
            j++;
         end
      end
      wr(dsw_pkg::OFF_ADDR, a);
      wr(dsw_pkg::OFF_LENGTH, rx ? 32'h4 : 32'(4 * n));
      if (rx)
         sts_send(32'hff800000 | 32'(4 * n));
   endtask

   task automatic wait_ev(logic [4:0] ev);
      int k;
      k = 0;
      while (irq !== 1'b1 && k < 3000) begin
         @(negedge clk);
         k++;
      end
      cmp("irq", 40'h1, {39'h0, irq});
      rd(dsw_pkg::OFF_IRQ_STAT, {27'h0, ev});
      wr(dsw_pkg::OFF_IRQ_CLR, {27'h0, ev});
      @(posedge clk);
      #1;
      cmp("irq", 40'h0, {39'h0, irq});
   endtask

   // main sequence
   initial begin
      void'($urandom(32'hf97b));
      repeat (12) @(posedge clk);
      sys_rst <= 1'b0;
      rd(dsw_pkg::OFF_CTRL, 32'h0);
      rd(dsw_pkg::OFF_BURST, 32'h0);
      rd(dsw_pkg::OFF_CLK_FREQ, 32'h0);
      rd(8'h24, 32'h0);
      wr(dsw_pkg::OFF_CTRL, 32'h11);
      rd(dsw_pkg::OFF_CLK_FREQ, dsw_pkg::CLK_FREQ_RST);
      wr(dsw_pkg::OFF_IRQ_EN, 32'h1f);
      rd(dsw_pkg::OFF_IRQ_EN, 32'h1f);
      xfer(32'h0, 2, 16, 1'b0);
      wait_ev(5'h01);
      slow <= 1'b1;
      xfer(32'h100, 20, 16, 1'b0);
      wait_ev(5'h01);
      wr(dsw_pkg::OFF_BURST, 32'h1);
      xfer(32'h400, 40, 32, 1'b0);
      wait_ev(5'h01);
      wr(dsw_pkg::OFF_LENGTH, 32'h0);
      wait_ev(5'h02);
      wr(dsw_pkg::OFF_LENGTH, 32'h80000008);
      wait_ev(5'h04);
      resp <= dsw_pkg::RESP_SLV;
      xfer(32'h0, 3, 32, 1'b0);
      wait_ev(5'h08);
      resp <= dsw_pkg::RESP_DEC;
      xfer(32'h0, 3, 32, 1'b0);
      wait_ev(5'h10);
      resp <= 2'h0;
      wr(dsw_pkg::OFF_CTRL, 32'h5);
      xfer(32'h80, 2, 32, 1'b0);
      wait_ev(5'h01);
      wr(dsw_pkg::OFF_CTRL, 32'h7);
      xfer(32'h40, 3, 32, 1'b1);
      wait_ev(5'h01);
      wr(dsw_pkg::OFF_CTRL, 32'h9);
      xfer(32'h201, 5, 32, 1'b0);
      wait_ev(5'h01);
      rd(dsw_pkg::OFF_STATUS, 32'h1);
      rd(dsw_pkg::OFF_LENGTH, 32'h14);
      final_report();
   end
endmodule
